/* core/invert_op_pkg.sv */
// Constants for the register complement instruction block
// What this block does
// - Invert register; d=0 to accumulator, d=1 back
// - Address 0..255; target and window bits one-bit
// - Window 0 common bank; 1 uses bank select
// - Indexed offset if extended, window 0, addr<=5F
// - Update negative and zero flags from result only
// - Opcode top six bits 000111, d, a, address
`default_nettype none
package invert_op_pkg;
  localparam logic [5:0] OPCODE_INVERT    = 6'h07;  // Top six bits 000111
  localparam int         OPC_HI           = 15;     // Opcode field top
  localparam int         OPC_LO           = 10;     // Opcode field bottom
  localparam int         DEST_BIT         = 9;      // Result target bit
  localparam int         WIN_BIT          = 8;      // Common window bit
  localparam logic [7:0] INDEX_LIMIT      = 8'h5F;  // Indexed window top
  localparam logic [7:0] ACCESS_SPLIT     = 8'h60;  // Common bank split
  localparam logic [3:0] ACCESS_HI_BANK   = 4'hF;   // Upper common bank
  localparam int         ADDR_W           = 12;     // Data memory address
  localparam int         STATUS_NEG_BIT   = 4;      // Negative flag position
  localparam int         STATUS_ZERO_BIT  = 2;      // Zero flag position
  localparam logic [7:0] RESET_BYTE       = 8'h00;  // Reset value of data
  localparam logic [11:0] RESET_ADDR      = 12'h000; // Reset address
endpackage
`default_nettype wire

/* core/invert_addr_gen.sv */
// Effective data-memory address generation for the invert instruction
`default_nettype none
module invert_addr_gen
  import invert_op_pkg::*;
(
  // Operand fields
  input  wire logic [7:0]        addr_i,
  input  wire logic              win_i,
  // Core state
  input  wire logic [3:0]        bank_i,
  input  wire logic              ext_i,
  input  wire logic [ADDR_W-1:0] index_base_i,
  // Result
  output logic      [ADDR_W-1:0] eff_addr_o,
  output logic                   indexed_o
);
  // Pure combinational decode; the caller registers it in phase one
  always_comb begin
    indexed_o = ext_i && !win_i && (addr_i <= INDEX_LIMIT);
    if (indexed_o) begin
      // Base pointer plus literal offset, wraps within memory
      eff_addr_o = index_base_i + {4'h0, addr_i};
    end else if (win_i) begin
      eff_addr_o = {bank_i, addr_i};
    end else if (addr_i < ACCESS_SPLIT) begin
      eff_addr_o = {4'h0, addr_i};
    end else begin
      // Upper part of the common bank maps to special registers
      eff_addr_o = {ACCESS_HI_BANK, addr_i};
    end
  end
endmodule
`default_nettype wire

/* core/invert_exec.sv */
// Four-phase executor of the register complement instruction
`default_nettype none
module invert_exec
  import invert_op_pkg::*;
(
  // Clock and reset
  input  wire logic              CLOCK_I,
  input  wire logic              RSTN_I,
  // Instruction issue
  input  wire logic              START_I,
  input  wire logic [15:0]       INSTR_I,
  // Core state
  input  wire logic [3:0]        BANK_SELECT_REGISTER_I,
  input  wire logic              EXT_SET_I,
  input  wire logic [ADDR_W-1:0] INDEX_BASE_I,
  input  wire logic [7:0]        ACC_I,
  input  wire logic [7:0]        STATUS_I,
  // Data memory
  output logic      [ADDR_W-1:0] MEM_ADDR_O,
  output logic                   MEM_RD_O,
  input  wire logic [7:0]        MEM_RDATA_I,
  output logic                   MEM_WR_O,
  output logic      [7:0]        MEM_WDATA_O,
  // Accumulator and status write-back
  output logic                   ACC_WR_O,
  output logic      [7:0]        ACC_WDATA_O,
  output logic                   STATUS_WR_O,
  output logic      [7:0]        STATUS_WDATA_O,
  // Progress
  output logic                   BUSY_O,
  output logic                   DONE_O,
  output logic                   ILLEGAL_O
);
  // Instruction phases
  typedef enum logic [2:0] {
    IDLE, DECODE, READ, PROCESS, WRITE
  } phase_t;

  // Whole module state
  typedef struct packed {
    phase_t            phase;    // Current phase
    logic              dest;     // Result target bit
    logic [ADDR_W-1:0] addr;     // Effective address
    logic [7:0]        data;     // Operand then result
    logic [7:0]        instr_lo; // Address operand
    logic              win;      // Window bit
    logic              done;     // Completion pulse
    logic              illegal;  // Foreign opcode pulse
  } state_t;

  state_t r;       // Registered state
  state_t next_r;  // Next value

  logic [ADDR_W-1:0] eff_addr;  // Decoded address
  logic              indexed;   // Indexed mode in use

  // Address resolution from latched operand fields
  invert_addr_gen u_addr (
    .addr_i       (r.instr_lo),
    .win_i        (r.win),
    .bank_i       (BANK_SELECT_REGISTER_I),
    .ext_i        (EXT_SET_I),
    .index_base_i (INDEX_BASE_I),
    .eff_addr_o   (eff_addr),
    .indexed_o    (indexed)
  );

  // Opcode match check
  function automatic logic is_invert(input logic [15:0] w);
    return w[OPC_HI:OPC_LO] == OPCODE_INVERT;
  endfunction

  // Sequencer; one phase per clock
  always_comb begin
    next_r         = r;
    next_r.done    = 1'b0;
    next_r.illegal = 1'b0;
    case (r.phase)
      IDLE: begin
        if (START_I) begin
          if (is_invert(INSTR_I)) begin
            next_r.dest     = INSTR_I[DEST_BIT];
            next_r.win      = INSTR_I[WIN_BIT];
            next_r.instr_lo = INSTR_I[7:0];
            next_r.phase    = DECODE;
          end else begin
            // Not ours: flag and stay idle
            next_r.illegal = 1'b1;
          end
        end
      end
      DECODE: begin
        next_r.addr  = eff_addr;
        next_r.phase = READ;
      end
      READ: begin
        next_r.data  = MEM_RDATA_I;
        next_r.phase = PROCESS;
      end
      PROCESS: begin
        next_r.data  = ~r.data;
        next_r.phase = WRITE;
      end
      WRITE: begin
        next_r.done  = 1'b1;
        next_r.phase = IDLE;
      end
      default: next_r.phase = IDLE;
    endcase
  end

  // State register, synchronous active-low reset
  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      r <= '{phase: IDLE, dest: 1'b0, addr: RESET_ADDR, data: RESET_BYTE,
             instr_lo: RESET_BYTE, win: 1'b0, done: 1'b0, illegal: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  // Memory side; read strobe in read phase, address held all through
  assign MEM_ADDR_O  = r.addr;
  assign MEM_RD_O    = (r.phase == READ);
  assign MEM_WR_O    = (r.phase == WRITE) && r.dest;
  assign MEM_WDATA_O = r.data;
  assign ACC_WR_O    = (r.phase == WRITE) && !r.dest;
  assign ACC_WDATA_O = r.data;

  // Only negative and zero change; others pass through untouched
  assign STATUS_WR_O = (r.phase == WRITE);
  always_comb begin
    STATUS_WDATA_O                  = STATUS_I;
    STATUS_WDATA_O[STATUS_NEG_BIT]  = r.data[7];
    STATUS_WDATA_O[STATUS_ZERO_BIT] = (r.data == 8'h00);
  end

  assign BUSY_O    = (r.phase != IDLE);
  assign DONE_O    = r.done;
  assign ILLEGAL_O = r.illegal;

  // Checks; all sample on the instruction clock; assertions sleep in reset, covers do not
  // Status bits other than negative and zero must pass untouched
  localparam logic [7:0] KEEP_MASK =
    ~((8'h01 << STATUS_NEG_BIT) | (8'h01 << STATUS_ZERO_BIT));

  // Written byte is the inverse of the byte read two phases earlier
  inv_result_a: assert property (
    @(posedge CLOCK_I) disable iff (!RSTN_I)
    MEM_RD_O |=> ##1 (MEM_WDATA_O == ~$past(MEM_RDATA_I, 2)))
    else $error("result is not the inverted operand");

  // Target bit 0 reaches the accumulator only, in the fourth phase
  dest_acc_a: assert property (
    @(posedge CLOCK_I) disable iff (!RSTN_I)
    (START_I && !BUSY_O && is_invert(INSTR_I) && !INSTR_I[DEST_BIT])
    |-> ##4 (ACC_WR_O && !MEM_WR_O))
    else $error("target 0 did not write accumulator");

  // Target bit 1 goes back to the register only
  dest_reg_a: assert property (
    @(posedge CLOCK_I) disable iff (!RSTN_I)
    (START_I && !BUSY_O && is_invert(INSTR_I) && INSTR_I[DEST_BIT])
    |-> ##4 (MEM_WR_O && !ACC_WR_O))
    else $error("target 1 did not write register");

  // Window bit 1: bank select value on top of the address operand
  bank_addr_a: assert property (
    @(posedge CLOCK_I) disable iff (!RSTN_I)
    (r.phase == DECODE && r.win)
    |=> (MEM_ADDR_O == {$past(BANK_SELECT_REGISTER_I), $past(r.instr_lo)}))
    else $error("banked address wrong");

  // Window bit 0 without indexing: lower or upper part of common bank
  access_addr_a: assert property (
    @(posedge CLOCK_I) disable iff (!RSTN_I)
    (r.phase == DECODE && !r.win
      && !(EXT_SET_I && r.instr_lo <= INDEX_LIMIT))
    |=> (MEM_ADDR_O[7:0] == $past(r.instr_lo)
      && MEM_ADDR_O[ADDR_W-1:8] == (($past(r.instr_lo) < ACCESS_SPLIT)
                                    ? 4'h0 : ACCESS_HI_BANK)))
    else $error("common bank address wrong");

  // Indexed mode only under its three conditions
  index_mode_a: assert property (
    @(posedge CLOCK_I) disable iff (!RSTN_I)
    indexed |-> (EXT_SET_I && !r.win && r.instr_lo <= INDEX_LIMIT))
    else $error("indexed mode without its conditions");

  // All three conditions met: base pointer plus literal offset, wrapping
  index_addr_a: assert property (
    @(posedge CLOCK_I) disable iff (!RSTN_I)
    (r.phase == DECODE && EXT_SET_I && !r.win && r.instr_lo <= INDEX_LIMIT)
    |=> (MEM_ADDR_O == $past(INDEX_BASE_I) + {4'h0, $past(r.instr_lo)}))
    else $error("indexed address wrong");

  // Status write: negative and zero from the result, rest untouched,
  // and it always rides along with exactly one destination write
  status_flags_a: assert property (
    @(posedge CLOCK_I) disable iff (!RSTN_I)
    STATUS_WR_O |->
      (STATUS_WDATA_O[STATUS_ZERO_BIT] == (MEM_WDATA_O == 8'h00)
      && STATUS_WDATA_O[STATUS_NEG_BIT] == MEM_WDATA_O[7]
      && (STATUS_WDATA_O & KEEP_MASK) == (STATUS_I & KEEP_MASK)
      && (ACC_WR_O ^ MEM_WR_O)))
    else $error("status flags wrong");

  // Foreign opcode: refused with a one-cycle pulse, nothing started
  foreign_op_a: assert property (
    @(posedge CLOCK_I) disable iff (!RSTN_I)
    (START_I && !BUSY_O && !is_invert(INSTR_I)) |=> (ILLEGAL_O && !BUSY_O))
    else $error("foreign opcode accepted");

  // One phase per clock: four busy cycles, then the done pulse
  four_phases_a: assert property (
    @(posedge CLOCK_I) disable iff (!RSTN_I)
    (START_I && !BUSY_O && is_invert(INSTR_I))
    |=> BUSY_O [*4] ##1 (DONE_O && !BUSY_O))
    else $error("instruction not four phases");

  // Register read happens in the second phase, never with a write-back
  read_phase_a: assert property (
    @(posedge CLOCK_I) disable iff (!RSTN_I)
    (START_I && !BUSY_O && is_invert(INSTR_I))
    |-> ##2 (MEM_RD_O && !STATUS_WR_O))
    else $error("register read not in second phase");

  // Main scenarios worth seeing at least once
  acc_path_c: cover property (@(posedge CLOCK_I) ACC_WR_O);
  reg_path_c: cover property (@(posedge CLOCK_I) MEM_WR_O);
  indexed_c: cover property (@(posedge CLOCK_I) indexed && r.phase == DECODE);
  zero_c: cover property (@(posedge CLOCK_I)
    STATUS_WR_O && STATUS_WDATA_O[STATUS_ZERO_BIT]);
  foreign_c: cover property (@(posedge CLOCK_I) ILLEGAL_O);
endmodule
`default_nettype wire

/* test/tb_invert_exec.sv */
// Self-checking bench for the four-phase register complement executor
`default_nettype none
module tb_invert_exec import invert_op_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic              ill;
    logic [ADDR_W-1:0] a;
    logic              d;
    logic [7:0]        v;
    logic [7:0]        s;
  } note_t;
  logic              clk, rstn, start, ext, mrd, mwr, awr, swr;
  logic              busy, done, ill;
  logic [15:0]       instr, w;
  logic [3:0]        bank;
  logic [ADDR_W-1:0] base, maddr;
  logic [7:0]        acc, stat, rd, rdata, mwd, awd, swd;
  note_t             q[$];      // Expected results, oldest first
  note_t             nt;        // Note under comparison
  int                n_errors, comparisons, n;
  // Memory shows junk outside the read strobe, never a stale byte
  assign rdata = mrd ? rd : ~rd;
  invert_exec i_invert_exec (.CLOCK_I(clk), .RSTN_I(rstn), .START_I(start),
    .INSTR_I(instr), .BANK_SELECT_REGISTER_I(bank), .EXT_SET_I(ext),
    .INDEX_BASE_I(base), .ACC_I(acc), .STATUS_I(stat), .MEM_ADDR_O(maddr),
    .MEM_RD_O(mrd), .MEM_RDATA_I(rdata), .MEM_WR_O(mwr), .MEM_WDATA_O(mwd),
    .ACC_WR_O(awr), .ACC_WDATA_O(awd), .STATUS_WR_O(swr),
    .STATUS_WDATA_O(swd), .BUSY_O(busy), .DONE_O(done), .ILLEGAL_O(ill));
  // Clock of 8 ns
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Compare tasks, one per kind of result, four-state exact except the two-state count
  task automatic cmp_addr(input logic [ADDR_W-1:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t address %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_byte(input logic [7:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t data %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t strobe %b expected %b", $time, got, exp);
    end
  endtask
  task automatic cmp_count(input int got, exp);
    comparisons++;
    if (got != exp) begin
      n_errors++;
      $display("ERROR %0t count %0d expected %0d", $time, got, exp);
    end
  endtask
  // Verdict and end of run
  task stop_test;
    $display("Counts: %0d errors, %0d comparisons", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Issue one word; poke retries START while busy, which must be ignored
  task automatic issue(input logic [15:0] wd, input bit poke);
    logic [7:0] f, r;
    note_t      t;
    f = wd[7:0];
    r = ~rd;
    if (wd[WIN_BIT]) t.a = {bank, f};
    else if (ext && f <= INDEX_LIMIT) t.a = base + ADDR_W'(f);
    else t.a = {(f >= ACCESS_SPLIT) ? ACCESS_HI_BANK : 4'h0, f};
    t.ill = (wd[OPC_HI:OPC_LO] != OPCODE_INVERT);
    t.d = wd[DEST_BIT];
    t.v = r;
    t.s = stat;
    t.s[STATUS_NEG_BIT] = r[7];
    t.s[STATUS_ZERO_BIT] = (r == 8'h00);
    q.push_back(t);
    start = 1'b1;
    instr = wd;
    @(negedge clk);
    start = 1'b0;
    n = 1;
    if (t.ill) begin
      @(negedge clk);
      return;
    end
    cmp_bit(busy, 1'b1);
    // Start is touched only where it changes, once per falling edge
    while (done !== 1'b1 && n < 12) begin
      if (poke && n == 2) begin
        start = 1'b1;
        instr = ~wd;
      end else if (start === 1'b1) begin
        start = 1'b0;
      end
      @(negedge clk);
      n++;
    end
    cmp_count(n, 5);
    cmp_bit(busy, 1'b0);
  endtask
  // Watcher: looks 1 ns after each rising edge, once outputs settled;
  // each write-back or refusal consumes the oldest note
  always @(posedge clk) begin
    #1;
    if (swr === 1'b1 || ill === 1'b1) begin
      if (q.size() == 0) cmp_count(1, 0);
      else begin
        nt = q.pop_front();
        cmp_bit(ill, nt.ill);
        cmp_bit(busy, !nt.ill);
        if (!nt.ill) begin
          cmp_addr(maddr, nt.a);
          cmp_bit(mwr, nt.d);
          cmp_bit(awr, !nt.d);
          cmp_byte(mwd, nt.v);
          cmp_byte(awd, nt.v);
          cmp_byte(swd, nt.s);
        end
      end
    end
  end
  // Main sequence, driven on falling edges
  initial begin
    {rstn, start, ext, instr, bank, base, acc, stat, rd} = '0;
    n_errors = 0;
    comparisons = 0;
    void'($urandom(32'h753B));
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    for (int i = 0; i < 300; i++) begin
      bank = 4'($urandom);
      ext = (i < 4) ? 1'b1 : 1'($urandom);
      base = ADDR_W'($urandom);
      stat = 8'($urandom);
      acc = 8'($urandom);
      rd = (i % 7 == 0) ? 8'hFF : 8'($urandom);
      w = {OPCODE_INVERT, 10'($urandom)};
      // Boundary of the indexed window first
      if (i < 4) w[8:0] = i[0] ? {1'b0, ACCESS_SPLIT} : {1'b0, INDEX_LIMIT};
      if (i % 13 == 5) w[15:10] = OPCODE_INVERT ^ (6'($urandom) | 6'h01);
      issue(w, i % 3 == 0);
    end
    @(negedge clk);
    cmp_count(q.size(), 0);
    $display("Random instruction test done");
    stop_test();
  end
  // Watchdog, far beyond the expected 1452 cycles
  initial begin
    #(8 * 20000);
    n_errors++;
    $display("ERROR %0t watchdog expired", $time);
    stop_test();
  end
endmodule
`default_nettype wire
